// [hw/drsc_top.sv]
// Serial command interpreter of a dual nonvolatile digital rheostat
`timescale 1ns/1ps
`default_nettype none

module drsc_top
  import drsc_pkg::*;
#(
  parameter int RELOAD_CYCLES = RELOAD_CYCLES_DEF,
  parameter int SAVE_CYCLES   = SAVE_CYCLES_DEF
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        serial_clock,
  input  wire logic        select_n,
  input  wire logic        serial_in,
  input  wire logic        write_protect_n,
  input  wire logic        preset_n,
  output logic             serial_out,
  output logic             serial_out_oe_n,
  output logic             ready,
  output logic             ready_oe_n,
  output logic [9:0]       wiper0,
  output logic [9:0]       wiper1
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Shift, step and saturate one wiper value for instructions 4-7, 12-15
  function automatic logic [9:0] drsc_step(input logic [9:0] w,
                                           input logic [3:0] instr);
    logic [9:0] r;
    r = w;
    case (instr[3:1])
      3'h2: r = {1'b0, w[9:1]};
      3'h3: r = (w == 10'h000) ? w : w - 10'h001;
      3'h6: r = {w[8:0], 1'b1};
      3'h7: r = (w == 10'h3FF) ? w : w + 10'h001;
      default: r = w;
    endcase
    return r;
  endfunction : drsc_step

  // ---------------------------------------------------------------
  // Link domain
  // ---------------------------------------------------------------
  drsc_link_if link_bus ();

  drsc_link u_link (
    .serial_clock    (serial_clock),
    .reset           (reset),
    .select_n        (select_n),
    .serial_in       (serial_in),
    .serial_out_oe_n (serial_out_oe_n),
    .port_if         (link_bus.link)
  );

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pins;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] level;
  logic [2:0] level_d;
  logic [2:0] next_level;

  assign pins = {select_n, preset_n, write_protect_n};

  // A change is taken only when the last two stages agree
  always_comb begin
    next_level = (~(sync2 ^ sync3) & sync2) | ((sync2 ^ sync3) & level);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sync1   <= PIN_RESET;
      sync2   <= PIN_RESET;
      sync3   <= PIN_RESET;
      level   <= PIN_RESET;
      level_d <= PIN_RESET;
    end else begin
      sync1   <= pins;
      sync2   <= sync1;
      sync3   <= sync2;
      level   <= next_level;
      level_d <= level;
    end
  end

  logic select_rise;
  logic preset_low;
  logic preset_rise;
  logic protected_now;

  assign select_rise   = level[PIN_SELECT] & ~level_d[PIN_SELECT];
  assign preset_low    = ~level[PIN_PRESET];
  assign preset_rise   = level[PIN_PRESET] & ~level_d[PIN_PRESET];
  assign protected_now = ~level[PIN_PROTECT];

  // ---------------------------------------------------------------
  // Frame fields
  // ---------------------------------------------------------------
  logic [3:0]  instr;
  logic [3:0]  addr;
  logic [15:0] data;
  logic        channel;
  logic        frame_ok;

  assign instr   = link_bus.word[INSTR_LSB +: 4];
  assign addr    = link_bus.word[ADDR_LSB +: 4];
  assign data    = link_bus.word[DATA_BITS-1:0];
  assign channel = link_bus.word[CHANNEL_BIT];
  // Daisy chains send longer frames; the last 24 bits are ours
  assign frame_ok = (link_bus.bit_count >= FULL_FRAME_BITS);

  // ---------------------------------------------------------------
  // Controller state
  // ---------------------------------------------------------------
  drsc_state_e                state;
  drsc_state_e                next_state;
  logic [BUSY_CNT_BITS-1:0]   busy_count;
  logic [BUSY_CNT_BITS-1:0]   next_busy_count;
  logic [9:0]                 wiper      [2];
  logic [9:0]                 next_wiper [2];
  logic [15:0]                nv         [NV_DEPTH];
  logic [15:0]                next_nv    [NV_DEPTH];
  logic                       readback;
  logic                       next_readback;
  logic [23:0]                resp;
  logic [23:0]                next_resp;

  always_comb begin
    next_state      = state;
    next_busy_count = busy_count;
    next_wiper      = wiper;
    next_nv         = nv;
    next_readback   = readback;
    next_resp       = resp;

    unique case (state)
      ST_IDLE: begin
        if (select_rise && frame_ok && !preset_low) begin
          next_readback = 1'b0;
          unique case (instr)
            INS_NOP: begin
            end
            INS_RESTORE: begin
              next_wiper[channel] = nv[{3'h0, channel}][WIPER_BITS-1:0];
            end
            INS_SAVE_WIPER: begin
              if (!protected_now) begin
                next_nv[{3'h0, channel}] = {6'h00, wiper[channel]};
              end
              next_state      = ST_BUSY;
              next_busy_count = BUSY_CNT_BITS'(SAVE_CYCLES);
            end
            INS_WRITE_NV: begin
              if (!protected_now) begin
                next_nv[addr] = data;
              end
              next_state      = ST_BUSY;
              next_busy_count = BUSY_CNT_BITS'(SAVE_CYCLES);
            end
            INS_RELOAD_ALL: begin
              next_wiper[0]   = nv[0][WIPER_BITS-1:0];
              next_wiper[1]   = nv[1][WIPER_BITS-1:0];
              next_state      = ST_BUSY;
              next_busy_count = BUSY_CNT_BITS'(RELOAD_CYCLES);
            end
            INS_READ_NV: begin
              next_readback   = 1'b1;
              next_resp       = {link_bus.word[23:16], nv[addr]};
              next_state      = ST_BUSY;
              next_busy_count = BUSY_CNT_BITS'(READ_CYCLES);
            end
            INS_READ_WIPER: begin
              next_readback   = 1'b1;
              next_resp       = {link_bus.word[23:16], 6'h00,
                                 wiper[channel]};
              next_state      = ST_BUSY;
              next_busy_count = BUSY_CNT_BITS'(READ_CYCLES);
            end
            INS_WRITE_WIPER: begin
              if (!protected_now) begin
                next_wiper[channel] = data[WIPER_BITS-1:0];
              end
            end
            INS_SHR_ONE, INS_DEC_ONE, INS_SHL_ONE, INS_INC_ONE: begin
              if (!protected_now) begin
                next_wiper[channel] = drsc_step(wiper[channel], instr);
              end
            end
            INS_SHR_ALL, INS_DEC_ALL, INS_SHL_ALL, INS_INC_ALL: begin
              if (!protected_now) begin
                next_wiper[0] = drsc_step(wiper[0], instr);
                next_wiper[1] = drsc_step(wiper[1], instr);
              end
            end
          endcase
        end
      end
      ST_BUSY: begin
        if (busy_count <= BUSY_CNT_BITS'(1)) begin
          next_state      = ST_IDLE;
          next_busy_count = '0;
        end else begin
          next_busy_count = busy_count - BUSY_CNT_BITS'(1);
        end
      end
    endcase

    // Preset overrides whatever the serial side is doing
    if (preset_low) begin
      next_wiper[0]   = WIPER_MIDSCALE;
      next_wiper[1]   = WIPER_MIDSCALE;
      next_state      = ST_BUSY;
      next_busy_count = BUSY_CNT_BITS'(RELOAD_CYCLES);
    end else if (preset_rise) begin
      next_wiper[0]   = nv[0][WIPER_BITS-1:0];
      next_wiper[1]   = nv[1][WIPER_BITS-1:0];
      next_state      = ST_BUSY;
      next_busy_count = BUSY_CNT_BITS'(RELOAD_CYCLES);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state      <= ST_IDLE;
      busy_count <= '0;
      readback   <= 1'b0;
      resp       <= SHIFT_RESET;
      wiper[0]   <= WIPER_MIDSCALE;
      wiper[1]   <= WIPER_MIDSCALE;
      for (int i = 0; i < NV_DEPTH; i++) begin
        nv[i] <= (i < 2) ? NV_WIPER_RESET : NV_USER_RESET;
      end
    end else begin
      state      <= next_state;
      busy_count <= next_busy_count;
      readback   <= next_readback;
      resp       <= next_resp;
      wiper      <= next_wiper;
      nv         <= next_nv;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign link_bus.readback = readback;
  assign link_bus.resp     = resp;

  // Open-drain pins: the value is always low, only the enable moves
  assign serial_out = 1'b0;
  assign ready      = 1'b0;
  assign ready_oe_n = (state == ST_IDLE);

  assign wiper0 = wiper[0];
  assign wiper1 = wiper[1];

endmodule : drsc_top

`default_nettype wire

// [hw/drsc_pkg.sv]
// Constants, codes and timing shared by the rheostat serial front end
`default_nettype none

package drsc_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int WORD_BITS   = 24;
  localparam int DATA_BITS   = 16;
  localparam int WIPER_BITS  = 10;
  localparam int NV_DEPTH    = 16;
  localparam int COUNT_BITS  = 5;
  localparam int INSTR_LSB   = 20;
  localparam int ADDR_LSB    = 16;
  localparam int CHANNEL_BIT = 16;
  localparam logic [4:0] FULL_FRAME_BITS = 5'h18;
  localparam logic [4:0] COUNT_SATURATE  = 5'h1F;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [9:0]  WIPER_MIDSCALE  = 10'h200;
  localparam logic [15:0] NV_WIPER_RESET  = 16'h0200;
  localparam logic [15:0] NV_USER_RESET   = 16'h0000;
  localparam logic [23:0] SHIFT_RESET     = 24'h000000;
  localparam logic [2:0]  PIN_RESET       = 3'h7;

  // Bit positions inside the synchronised pin vector
  localparam int PIN_SELECT  = 2;
  localparam int PIN_PRESET  = 1;
  localparam int PIN_PROTECT = 0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLOCK_KHZ      = 40000;
  localparam int T_RELOAD_US    = 1000;
  localparam int T_READ_US      = 100;
  localparam int T_SAVE_US      = 20000;
  localparam int RELOAD_CYCLES_DEF = (T_RELOAD_US * CLOCK_KHZ) / 1000;
  localparam int READ_CYCLES       = (T_READ_US * CLOCK_KHZ) / 1000;
  localparam int SAVE_CYCLES_DEF   = (T_SAVE_US * CLOCK_KHZ) / 1000;
  localparam int BUSY_CNT_BITS     = 20;

  // ---------------------------------------------------------------
  // Instruction codes and controller states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    INS_NOP         = 4'h0,
    INS_RESTORE     = 4'h1,
    INS_SAVE_WIPER  = 4'h2,
    INS_WRITE_NV    = 4'h3,
    INS_SHR_ONE     = 4'h4,
    INS_SHR_ALL     = 4'h5,
    INS_DEC_ONE     = 4'h6,
    INS_DEC_ALL     = 4'h7,
    INS_RELOAD_ALL  = 4'h8,
    INS_READ_NV     = 4'h9,
    INS_READ_WIPER  = 4'hA,
    INS_WRITE_WIPER = 4'hB,
    INS_SHL_ONE     = 4'hC,
    INS_SHL_ALL     = 4'hD,
    INS_INC_ONE     = 4'hE,
    INS_INC_ALL     = 4'hF
  } drsc_instr_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } drsc_state_e;

endpackage : drsc_pkg

`default_nettype wire

// [hw/drsc_link_if.sv]
// Signals between the serial-clock link logic and the core controller
`timescale 1ns/1ps
`default_nettype none

interface drsc_link_if;
  logic [23:0] word;
  logic [4:0]  bit_count;
  logic        readback;
  logic [23:0] resp;

  modport link (output word, output bit_count,
                input readback, input resp);
  modport core (input word, input bit_count,
                output readback, output resp);
endinterface : drsc_link_if

`default_nettype wire

// [hw/drsc_link.sv]
// Serial-clock domain: input shift register, bit count and serial output
`timescale 1ns/1ps
`default_nettype none

module drsc_link
  import drsc_pkg::*;
(
  input  wire logic   serial_clock,
  input  wire logic   reset,
  input  wire logic   select_n,
  input  wire logic   serial_in,
  output logic        serial_out_oe_n,
  drsc_link_if.link   port_if
);

  logic [23:0] shift;
  logic [23:0] next_shift;
  logic [4:0]  count;
  logic [4:0]  next_count;
  logic        in_frame;
  logic        first_readback;
  logic        out_bit;

  // The core only changes readback and resp after a frame and holds them
  // while the ready flag is low, so they are static by the next frame.
  assign first_readback = !in_frame && port_if.readback;

  // ---------------------------------------------------------------
  // Shift register
  // ---------------------------------------------------------------
  always_comb begin
    next_shift = shift;
    next_count = count;
    if (!select_n) begin
      if (first_readback) begin
        next_shift = {port_if.resp[22:0], serial_in};
      end else begin
        next_shift = {shift[22:0], serial_in};
      end
      if (!in_frame) begin
        next_count = 5'h01;
      end else if (count != COUNT_SATURATE) begin
        next_count = count + 5'h01;
      end
    end
  end

  // The link clock stands still between frames, so the core reset clears
  // this register without waiting for a link edge.
  always_ff @(posedge serial_clock or posedge reset) begin
    if (reset) begin
      shift <= SHIFT_RESET;
      count <= 5'h00;
    end else begin
      shift <= next_shift;
      count <= next_count;
    end
  end

  // frame ends on select high
  // Only this flag clears at select high; the count is held so the core
  // can still judge the frame length after the select crossing.
  always_ff @(posedge serial_clock or posedge select_n or posedge reset) begin
    if (select_n || reset) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  assign out_bit = first_readback ? port_if.resp[23] : shift[23];

  assign serial_out_oe_n = select_n | out_bit;

  assign port_if.word      = shift;
  assign port_if.bit_count = count;

endmodule : drsc_link

`default_nettype wire

// [dv/drsc_host.sv]
// Host model: frames 24-bit words on the serial link, captures readback
`timescale 1ns/1ps
`default_nettype none

module drsc_host (
  output logic      serial_clock,
  output logic      select_n,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe_n
);
  // Pull-up gives the high level whenever the device lets go of the line
  logic line;
  assign line = serial_out_oe_n ? 1'b1 : serial_out;
  initial begin
    serial_clock = 1'b0;
    select_n     = 1'b1;
    serial_in    = 1'b0;
  end
  // ---------------------------------------------------------------
  // Frame transfer
  // ---------------------------------------------------------------
  // msb first, whole frame
  task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
    select_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      serial_in = tx[i];
      #32;
      rx[i] = line;
      serial_clock = 1'b1;
      #32;
      serial_clock = 1'b0;
    end
    #64;
    select_n  = 1'b1;
    // Released data line must not look like a held bit
    serial_in = ~tx[0];
  endtask : xfer
endmodule : drsc_host

`default_nettype wire

// [dv/drsc_props.sv]
// Port-level properties of the rheostat serial front end
`timescale 1ns/1ps
`default_nettype none

module drsc_props
  import drsc_pkg::*;
#(
  parameter int RELOAD_CYCLES = RELOAD_CYCLES_DEF,
  parameter int SAVE_CYCLES   = SAVE_CYCLES_DEF
) (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       serial_clock,
  input wire logic       select_n,
  input wire logic       serial_in,
  input wire logic       write_protect_n,
  input wire logic       preset_n,
  input wire logic       serial_out,
  input wire logic       serial_out_oe_n,
  input wire logic       ready,
  input wire logic       ready_oe_n,
  input wire logic [9:0] wiper0,
  input wire logic [9:0] wiper1
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ---------------------------------------------------------------
  // Busy length, and whether preset caused it
  // ---------------------------------------------------------------
  logic [19:0] low_len;
  logic [19:0] next_low_len;
  logic        by_preset;
  logic        next_by_preset;
  always_comb begin
    next_low_len   = ready_oe_n ? 20'h00000 : low_len + 20'h00001;
    next_by_preset = (by_preset | ~preset_n) & ~(ready_oe_n & preset_n);
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      low_len   <= 20'h00000;
      by_preset <= 1'b0;
    end else begin
      low_len   <= next_low_len;
      by_preset <= next_by_preset;
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  busy_len_a: assert property ($rose(ready_oe_n) && !by_preset |->
    low_len == READ_CYCLES || low_len == RELOAD_CYCLES ||
    low_len == SAVE_CYCLES) else $error("busy period of wrong length");
  preset_len_a: assert property ($rose(ready_oe_n) && by_preset |->
    low_len > RELOAD_CYCLES) else $error("preset busy too short");
  wiper_mid_a: assert property (!preset_n [*8] |->
    wiper0 == WIPER_MIDSCALE && wiper1 == WIPER_MIDSCALE)
    else $error("wipers not midscale under preset");
  preset_busy_a: assert property (!preset_n [*8] |-> !ready_oe_n)
    else $error("ready not low under preset");
  out_release_a: assert property (select_n |-> serial_out_oe_n)
    else $error("serial output driven while deselected");
  open_drain_a: assert property (serial_out == 1'b0 && ready == 1'b0)
    else $error("open-drain value not low");
  frame_hold_a: assert property ((!select_n && preset_n) [*8] |->
    $stable(wiper0) && $stable(wiper1)) else $error("wiper moved in frame");
  busy_hold_a: assert property (!ready_oe_n && $past(!ready_oe_n) &&
    preset_n && $past(preset_n, 12) |-> $stable(wiper0) && $stable(wiper1))
    else $error("wiper moved while busy");
  reset_mid_a: assert property ($fell(reset) |-> ready_oe_n &&
    wiper0 == WIPER_MIDSCALE && wiper1 == WIPER_MIDSCALE)
    else $error("wrong values after reset");
  cover property ($rose(ready_oe_n) && low_len == READ_CYCLES);
  cover property ($rose(ready_oe_n) && by_preset);
  cover property ($rose(select_n) && !write_protect_n);
endmodule : drsc_props

bind drsc_top drsc_props #(.RELOAD_CYCLES(RELOAD_CYCLES),
  .SAVE_CYCLES(SAVE_CYCLES)) chk (.clock(clock), .reset(reset),
  .serial_clock(serial_clock), .select_n(select_n),
  .serial_in(serial_in), .write_protect_n(write_protect_n),
  .preset_n(preset_n), .serial_out(serial_out),
  .serial_out_oe_n(serial_out_oe_n), .ready(ready),
  .ready_oe_n(ready_oe_n), .wiper0(wiper0), .wiper1(wiper1));

`default_nettype wire

// [dv/drsc_top_bench.sv]
// Self-checking bench of the rheostat serial front end
`timescale 1ns/1ps
`default_nettype none

module drsc_top_bench;
  import drsc_pkg::*;
  logic        clock = 1'b0;
  logic        reset = 1'b0;
  logic        write_protect_n = 1'b1;
  logic        preset_n = 1'b1;
  logic        serial_clock, select_n, serial_in, serial_out;
  logic        serial_out_oe_n, ready, ready_oe_n, rd_kind;
  logic [9:0]  wiper0, wiper1, w0, w1;
  logic [15:0] nv [16];
  logic [15:0] r;
  logic [23:0] rx, got, e;
  logic [23:0] exp_q [$];
  logic [3:0]  ops [8] = '{4'h6, 4'h7, 4'h4, 4'h5, 4'hE, 4'hF, 4'hC, 4'hD};
  int          err_count = 0;
  int          comparisons = 0;
  event        result;

  always #12.5 clock = ~clock;
  drsc_host host (.serial_clock(serial_clock), .select_n(select_n),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n));
  drsc_top #(.RELOAD_CYCLES(20), .SAVE_CYCLES(40)) uut (.clock(clock),
    .reset(reset), .serial_clock(serial_clock), .select_n(select_n),
    .serial_in(serial_in), .write_protect_n(write_protect_n),
    .preset_n(preset_n), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .ready(ready),
    .ready_oe_n(ready_oe_n), .wiper0(wiper0), .wiper1(wiper1));

  // ---------------------------------------------------------------
  // Result watcher
  // ---------------------------------------------------------------
  always @(result) begin
    got = rd_kind ? rx : {4'h0, wiper1, wiper0};
    e = exp_q.pop_front();
    comparisons++;
    if (got !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", rd_kind ? "readback" : "wipers",
        e, got);
    end
  end

  task automatic finish_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : tick

  task automatic wait_ready();
    for (int i = 0; ready_oe_n !== 1'b1; i++) begin
      if (i > 5000) begin
        err_count++;
        $display("BAD ready_oe_n expected 1 seen %b", ready_oe_n);
        finish_test();
      end
      tick(1);
    end
  endtask : wait_ready

  task automatic chk(input logic kind, input logic [23:0] v);
    exp_q.push_back(v);
    rd_kind = kind;
    -> result;
    #1;
  endtask : chk

  function automatic logic [9:0] step(input logic [3:0] c,
                                      input logic [9:0] v);
    case (c[3:1])
      3'h2: step = v >> 1;
      3'h3: step = (v == 10'h000) ? v : v - 10'h001;
      3'h6: step = {v[8:0], 1'b1};
      default: step = (v == 10'h3FF) ? v : v + 10'h001;
    endcase
  endfunction : step

  // Sends one frame once ready, then updates the expected device state
  task automatic cmd(input logic [3:0] c, input logic [3:0] a,
                     input logic [15:0] d);
    logic p;
    p = write_protect_n;
    wait_ready();
    host.xfer({c, a, d}, rx);
    tick(12);
    wait_ready();
    case (c)
      INS_RESTORE: if (a[0]) w1 = nv[1][9:0]; else w0 = nv[0][9:0];
      INS_SAVE_WIPER: if (p) nv[a[0]] = {6'h00, a[0] ? w1 : w0};
      INS_WRITE_NV: if (p) nv[a] = d;
      INS_RELOAD_ALL: begin
        w0 = nv[0][9:0];
        w1 = nv[1][9:0];
      end
      INS_WRITE_WIPER: if (p && a[0]) w1 = d[9:0]; else if (p) w0 = d[9:0];
      INS_NOP, INS_READ_NV, INS_READ_WIPER: ;
      default: if (p) begin
        if (c[0] | ~a[0]) w0 = step(c, w0);
        if (c[0] | a[0]) w1 = step(c, w1);
      end
    endcase
    chk(1'b0, {4'h0, w1, w0});
  endtask : cmd

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    // A real rising edge, so the link's asynchronous clears all see it
    #1;
    reset = 1'b1;
    void'($urandom(32'h41AB));
    foreach (nv[i]) nv[i] = (i < 2) ? NV_WIPER_RESET : NV_USER_RESET;
    w0 = 10'h200;
    w1 = 10'h200;
    r = 16'($urandom);
    repeat (8) @(posedge clock);
    #2;
    reset = 1'b0;
    tick(4);
    chk(1'b0, {4'h0, w1, w0});
    cmd(INS_WRITE_WIPER, 4'h0, r);
    cmd(INS_WRITE_WIPER, 4'h1, {r[15:10], 10'h3FF});
    for (int i = 0; i < 2; i++) begin
      cmd(INS_READ_WIPER, i[3:0], r);
      cmd(INS_NOP, 4'h0, 16'h0000);
      chk(1'b1, {INS_READ_WIPER, i[3:0], 6'h00, i ? w1 : w0});
    end
    cmd(INS_NOP, 4'h0, r);
    chk(1'b1, 24'h000000);
    cmd(INS_NOP, 4'h0, 16'h0000);
    chk(1'b1, {8'h00, r});
    cmd(INS_WRITE_WIPER, 4'h0, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      cmd(ops[i % 8], {3'h0, r[i]}, 16'($urandom));
    end
    cmd(INS_WRITE_WIPER, 4'h0, 16'h0155);
    cmd(INS_SAVE_WIPER, 4'h0, r);
    cmd(INS_WRITE_WIPER, 4'h0, 16'h00AA);
    cmd(INS_RELOAD_ALL, 4'h0, r);
    cmd(INS_WRITE_NV, 4'h5, r);
    cmd(INS_READ_NV, 4'h5, 16'h0000);
    cmd(INS_NOP, 4'h0, 16'h0000);
    chk(1'b1, {INS_READ_NV, 4'h5, nv[5]});
    cmd(INS_WRITE_NV, 4'h1, r);
    cmd(INS_RESTORE, 4'h1, 16'h0000);
    write_protect_n = 1'b0;
    cmd(INS_WRITE_WIPER, 4'h1, 16'h00F0);
    cmd(INS_INC_ALL, 4'h0, 16'h0000);
    cmd(INS_SAVE_WIPER, 4'h0, 16'h0000);
    cmd(INS_WRITE_NV, 4'h1, 16'h0123);
    cmd(INS_WRITE_WIPER, 4'h0, 16'h0033);
    cmd(INS_RELOAD_ALL, 4'h0, 16'h0000);
    cmd(INS_NOP, 4'h0, 16'h0000);
    write_protect_n = 1'b1;
    cmd(INS_READ_WIPER, 4'h0, 16'h0000);
    host.xfer({INS_READ_WIPER, 4'h0, 16'h0000}, rx);
    tick(12);
    host.xfer({INS_WRITE_WIPER, 4'h0, 16'h0011}, rx);
    tick(12);
    wait_ready();
    chk(1'b0, {4'h0, w1, w0});
    cmd(INS_NOP, 4'h0, 16'h0000);
    cmd(INS_WRITE_WIPER, 4'h1, 16'h0077);
    preset_n = 1'b0;
    tick(20);
    chk(1'b0, {4'h0, 10'h200, 10'h200});
    preset_n = 1'b1;
    tick(12);
    wait_ready();
    chk(1'b0, {4'h0, nv[1][9:0], nv[0][9:0]});
    finish_test();
  end
endmodule : drsc_top_bench

`default_nettype wire
